// ---- verilog/afc_ctrl.sv ----
// Purpose: host controller pacing writes, reads, resets and suspends to a parallel flash
// Assumes: flash status pin in ready/busy mode; 16-bit data bus
// Notes:   all pin outputs are registered
`timescale 1ns/1ps
`default_nettype none
`include "afc_defines.svh"
module afc_ctrl
	import afc_pkg::*;
#(
	parameter int RST_CYC  = `AFC_RSTLOW_CYC,
	parameter int GAP_CYC  = `AFC_SUSP_GAP_CYC,
	parameter int TO_SCALE = 1
) (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        req_valid_i,
	input  wire afc_op_e     req_op_i,
	input  wire afc_to_e     req_to_i,
	input  wire logic        req_suspend_i,
	input  wire logic        req_resume_i,
	input  wire logic        req_program_enable_supply_i,
	input  wire logic [22:0] req_addr_i,
	input  wire logic [15:0] req_wdata_i,
	input  wire logic        flash_reset_i,
	output logic             req_ready_o,
	output logic             rsp_valid_o,
	output logic [15:0]      rsp_rdata_o,
	output logic             rsp_error_o,
	output logic             rsp_timeout_o,
	output logic [2:0]       chip_select_group_n_o,
	output logic             we_n_o,
	output logic             oe_n_o,
	output logic             reset_powerdown_n_o,
	output logic             program_enable_supply_o,
	output logic [22:0]      addr_o,
	output logic [15:0]      dq_o,
	output logic             dq_oe_o,
	input  wire logic [15:0] dq_i,
	input  wire logic        status_pin_i
);
	typedef enum logic [3:0] {
		ST_RESET, ST_RECOV, ST_IDLE, ST_WR_PULSE, ST_WR_HIGH,
		ST_RD_WAIT, ST_BUSY_ARM, ST_BUSY, ST_DONE
	} afc_st_e;

	afc_st_e     st_q;
	afc_cnt_t    cnt_q;
	afc_cnt_t    to_q;
	afc_cnt_t    gap_q;
	logic        after_wr_q;
	logic        low_seen_q;
	logic [15:0] dq_s;
	logic        sts_s;
	afc_cnt_t    rd_lim_s;

	function automatic afc_cnt_t to_limit(input afc_to_e k);
		unique case (k)
			AFC_TO_BUF:   to_limit = `AFC_US_CYC(`AFC_TO_BUF_US);
			AFC_TO_WORD:  to_limit = `AFC_US_CYC(`AFC_TO_WORD_US);
			AFC_TO_BLOCK: to_limit = `AFC_MS_CYC(`AFC_TO_BLK_MS);
			AFC_TO_LOCK:  to_limit = `AFC_US_CYC(`AFC_TO_LOCK_US);
			AFC_TO_CLR:   to_limit = `AFC_MS_CYC(`AFC_TO_CLR_MS);
			AFC_TO_ERASE: to_limit = `AFC_MS_CYC(`AFC_TO_ERASE_MS);
			default:      to_limit = `AFC_US_CYC(`AFC_TO_SUSP_US);
		endcase
	endfunction : to_limit

	afc_sync #(.W(17)) u_sync (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.d_i       ({status_pin_i, dq_i}),
		.q_o       ({sts_s, dq_s})
	);

	// Access time always, write recovery on top after a write
	assign rd_lim_s = after_wr_q ? afc_cnt_t'(`AFC_WREC_CYC - 1)
	                             : afc_cnt_t'(`AFC_RD_CYC - 1);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			st_q       <= ST_RESET;
			cnt_q      <= '0;
			after_wr_q <= 1'b0;
			low_seen_q <= 1'b0;
		end else if (flash_reset_i && st_q != ST_RESET) begin
			st_q  <= ST_RESET;
			cnt_q <= '0;
		end else begin
			unique case (st_q)
				ST_RESET: begin
					// One count covers both pulse width and power-up hold
					if (cnt_q >= afc_cnt_t'(RST_CYC - 1)) begin
						st_q  <= ST_RECOV;
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				ST_RECOV: begin
					if (cnt_q >= afc_cnt_t'(`AFC_RECOV_CYC - 1)) begin
						st_q <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				ST_IDLE: begin
					cnt_q <= '0;
					if (req_valid_i) begin
						if (req_op_i == AFC_OP_WRITE) begin
							st_q <= ST_WR_PULSE;
						end else if (req_op_i == AFC_OP_READ) begin
							// Data must pass the synchroniser before capture
							st_q <= ST_RD_WAIT;
						end else begin
							st_q       <= ST_BUSY_ARM;
							low_seen_q <= 1'b0;
						end
					end
				end
				ST_WR_PULSE: begin
					if (cnt_q >= afc_cnt_t'(`AFC_WP_CYC - 1)) begin
						st_q  <= ST_WR_HIGH;
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				ST_WR_HIGH: begin
					if (cnt_q >= afc_cnt_t'(`AFC_WPH_CYC - 1)) begin
						st_q       <= ST_DONE;
						after_wr_q <= 1'b1;
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				ST_RD_WAIT: begin
					if (cnt_q >= rd_lim_s) begin
						st_q       <= ST_DONE;
						after_wr_q <= 1'b0;
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				ST_BUSY_ARM: begin
					// Device may take 500 ns to pull status low; a seen low ends the wait
					if (!sts_s) begin
						low_seen_q <= 1'b1;
					end
					if (low_seen_q || cnt_q >= afc_cnt_t'(`AFC_STSLOW_CYC)) begin
						st_q <= ST_BUSY;
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				ST_BUSY: begin
					if (sts_s || to_q == '0) begin
						st_q <= ST_DONE;
					end
				end
				ST_DONE: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Timeout, maxima used only as error limits
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			to_q <= '0;
		end else if (st_q == ST_IDLE && req_valid_i && req_op_i == AFC_OP_WAIT) begin
			to_q <= to_limit(req_to_i) / afc_cnt_t'(TO_SCALE);
		end else if ((st_q == ST_BUSY || st_q == ST_BUSY_ARM) && to_q != '0) begin
			to_q <= to_q - 32'h1;
		end
	end

	// ------------------------------------------------------------
	// Suspend spacing after a resume
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			gap_q <= '0;
		end else if (st_q == ST_IDLE && req_valid_i && req_resume_i) begin
			gap_q <= afc_cnt_t'(GAP_CYC);
		end else if (gap_q != '0) begin
			gap_q <= gap_q - 32'h1;
		end
	end

	// ------------------------------------------------------------
	// Pins and answer, all registered
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			chip_select_group_n_o   <= 3'h7;
			we_n_o                  <= 1'b1;
			oe_n_o                  <= 1'b1;
			reset_powerdown_n_o     <= 1'b0;
			program_enable_supply_o <= 1'b0;
			addr_o                  <= '0;
			dq_o                    <= '0;
			dq_oe_o                 <= 1'b0;
			req_ready_o             <= 1'b0;
			rsp_valid_o             <= 1'b0;
			rsp_rdata_o             <= '0;
			rsp_error_o             <= 1'b0;
			rsp_timeout_o           <= 1'b0;
		end else begin
			reset_powerdown_n_o <= (st_q != ST_RESET) && !flash_reset_i;
			rsp_valid_o         <= (st_q == ST_DONE);
			req_ready_o         <= (st_q == ST_IDLE) && !req_valid_i;
			if (st_q == ST_IDLE && req_valid_i) begin
				addr_o <= req_addr_i;
				dq_o   <= req_wdata_i;
				// Raise supply with the request; drop only once a status read is clean
				if (req_program_enable_supply_i) begin
					program_enable_supply_o <= 1'b1;
				end
				rsp_error_o   <= req_suspend_i && (gap_q != '0);
				rsp_timeout_o <= 1'b0;
			end
			// Both strobes framed together; one edge pair suffices
			if (st_q == ST_IDLE && req_valid_i && req_op_i == AFC_OP_WRITE &&
			    !(req_suspend_i && gap_q != '0)) begin
				chip_select_group_n_o <= 3'h0;
				we_n_o                <= 1'b0;
				oe_n_o                <= 1'b1;
				dq_oe_o               <= 1'b1;
			end else if (st_q == ST_WR_PULSE && cnt_q >= afc_cnt_t'(`AFC_WP_CYC - 1)) begin
				chip_select_group_n_o <= 3'h7;
				we_n_o                <= 1'b1;
			end else if (st_q == ST_WR_HIGH && cnt_q >= afc_cnt_t'(`AFC_WPH_CYC - 1)) begin
				dq_oe_o <= 1'b0;
			end
			if (st_q == ST_IDLE && req_valid_i && req_op_i == AFC_OP_READ) begin
				chip_select_group_n_o <= 3'h0;
				we_n_o                <= 1'b1;
				oe_n_o                <= after_wr_q;
			end else if (st_q == ST_RD_WAIT) begin
				oe_n_o <= 1'b0;
			end
			if (st_q == ST_DONE && !oe_n_o) begin
				rsp_rdata_o           <= dq_s;
				chip_select_group_n_o <= 3'h7;
				oe_n_o                <= 1'b1;
				if ((dq_s[7:0] & `AFC_SR_ERR_MASK) == 8'h00 && dq_s[`AFC_SR_READY_BIT]) begin
					program_enable_supply_o <= 1'b0;
				end
			end
			if (st_q == ST_BUSY && !sts_s && to_q == '0) begin
				rsp_timeout_o <= 1'b1;
			end
			if (st_q == ST_RESET) begin
				chip_select_group_n_o <= 3'h7;
				we_n_o                <= 1'b1;
				oe_n_o                <= 1'b1;
				dq_oe_o               <= 1'b0;
			end
		end
	end
endmodule : afc_ctrl
`default_nettype wire

// ---- verilog/afc_defines.svh ----
// Purpose: timing counts and field positions for the flash write controller
// Assumes: 50 MHz reference clock, 20 ns period
// Notes:   times in their own unit, cycle counts derived and rounded
`ifndef AFC_DEFINES_SVH
`define AFC_DEFINES_SVH

`define AFC_CLK_NS          20
// Least times round up
`define AFC_WP_NS           60
`define AFC_WP_CYC          ((`AFC_WP_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_WPH_NS          30
`define AFC_WPH_CYC         ((`AFC_WPH_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_WREC_NS         35
`define AFC_AVQV_NS         75
`define AFC_WREC_CYC        ((`AFC_WREC_NS + `AFC_AVQV_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
// Access time plus one cycle for the second synchroniser stage
`define AFC_RD_CYC          ((`AFC_AVQV_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS + 1)
`define AFC_STSLOW_NS       500
`define AFC_STSLOW_CYC      ((`AFC_STSLOW_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_RSTLOW_US       25
`define AFC_PWRUP_US        60
`define AFC_RSTLOW_CYC      ((`AFC_PWRUP_US * 1000 + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_RECOV_NS        210
`define AFC_RECOV_CYC       ((`AFC_RECOV_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_SUSP_GAP_US     475
`define AFC_SUSP_GAP_CYC    ((`AFC_SUSP_GAP_US * 1000 + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
// Timeout maxima, longest time rounds down
`define AFC_TO_BUF_US       654
`define AFC_TO_WORD_US      175
`define AFC_TO_LOCK_US      60
`define AFC_TO_SUSP_US      20
`define AFC_TO_BLK_MS       2400
`define AFC_TO_CLR_MS       700
`define AFC_TO_ERASE_MS     4000
// Divide first so the second-long limits stay inside 32 bits
`define AFC_US_CYC(x)       ((x) * (1000 / `AFC_CLK_NS))
`define AFC_MS_CYC(x)       ((x) * (1000000 / `AFC_CLK_NS))
// Status word error bits that must be clear
`define AFC_SR_ERR_MASK     8'h3A
`define AFC_SR_READY_BIT    7

`endif

// ---- verilog/afc_pkg.sv ----
// Purpose: types for the flash write controller
// Assumes: none
// Notes:   counts live in afc_defines.svh
`default_nettype none
package afc_pkg;
	typedef enum logic [1:0] {
		AFC_OP_WRITE,
		AFC_OP_READ,
		AFC_OP_WAIT
	} afc_op_e;

	typedef enum logic [2:0] {
		AFC_TO_BUF,
		AFC_TO_WORD,
		AFC_TO_BLOCK,
		AFC_TO_LOCK,
		AFC_TO_CLR,
		AFC_TO_ERASE,
		AFC_TO_SUSP
	} afc_to_e;

	typedef logic [31:0] afc_cnt_t;
endpackage : afc_pkg
`default_nettype wire

// ---- verilog/afc_sync.sv ----
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: one clock domain
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module afc_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule : afc_sync
`default_nettype wire

// ---- tb/afc_ctrl_chk.sv ----
// Purpose: pin timing checks for the flash write controller
// Assumes: one clock, synchronous active-low reset
// Notes:   long low times are counted in helper logic
`timescale 1ns/1ps
`default_nettype none
module afc_ctrl_chk #(
	parameter int RST_CYC = 20,
	parameter int GAP_CYC = 50
) (
	input wire logic        ref_clk_i,
	input wire logic        rst_n_i,
	input wire logic        req_valid_i,
	input wire logic        req_ready_o,
	input wire logic        req_suspend_i,
	input wire logic        req_resume_i,
	input wire logic        rsp_valid_o,
	input wire logic [15:0] rsp_rdata_o,
	input wire logic [2:0]  chip_select_group_n_o,
	input wire logic        we_n_o,
	input wire logic        oe_n_o,
	input wire logic        reset_powerdown_n_o,
	input wire logic        program_enable_supply_o
);
	int low_q;
	int gap_q;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Not reset: the pin is low through a reset too and that time counts
	always_ff @(posedge ref_clk_i) begin
		low_q <= reset_powerdown_n_o ? 0 : low_q + 1;
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i)
			gap_q <= GAP_CYC;
		else if (req_valid_i && req_ready_o && req_resume_i)
			gap_q <= 0;
		else if (gap_q < GAP_CYC)
			gap_q <= gap_q + 1;
	end
	chk_strobe_excl: assert property (we_n_o || oe_n_o)
		else $error("write and output strobes low together");
	chk_pulse_width: assert property ($fell(we_n_o) |->
		(!we_n_o && chip_select_group_n_o == 3'h0) [*3])
		else $error("write pulse shorter than three cycles");
	chk_write_done: assert property ($fell(we_n_o) |-> ##[5:8] rsp_valid_o)
		else $error("write cycle not answered");
	chk_reset_low: assert property ($rose(reset_powerdown_n_o) |-> low_q >= RST_CYC)
		else $error("reset pin released too early");
	chk_recov_gap: assert property ($rose(reset_powerdown_n_o) |->
		(chip_select_group_n_o == 3'h7) [*8] ##1 (chip_select_group_n_o == 3'h7) [*3])
		else $error("select too soon after reset release");
	chk_read_recov: assert property ($rose(we_n_o) |-> oe_n_o [*6])
		else $error("read too soon after write");
	chk_supply_hold: assert property ($fell(program_enable_supply_o) && reset_powerdown_n_o |->
		rsp_rdata_o[7] && (rsp_rdata_o & 16'h003A) == 16'h0000)
		else $error("supply dropped without good status");
	chk_susp_gap: assert property (req_valid_i && req_ready_o && req_suspend_i &&
		gap_q < GAP_CYC |=> we_n_o [*8])
		else $error("suspend strobed inside resume gap");
endmodule : afc_ctrl_chk
bind afc_ctrl afc_ctrl_chk #(.RST_CYC(RST_CYC), .GAP_CYC(GAP_CYC)) u_chk (
	.ref_clk_i, .rst_n_i, .req_valid_i, .req_ready_o, .req_suspend_i, .req_resume_i,
	.rsp_valid_o, .rsp_rdata_o, .chip_select_group_n_o, .we_n_o, .oe_n_o,
	.reset_powerdown_n_o, .program_enable_supply_o
);
`default_nettype wire

// ---- tb/afc_flash_model.sv ----
// Purpose: behavioural parallel flash seen at its control pins
// Assumes: status pin in ready/busy mode with a pull-up
// Notes:   operation length comes from the bench, so fast and slow parts are tried
`timescale 1ns/1ps
`default_nettype none
module afc_flash_model (
	input  wire logic        ref_clk_i,
	input  wire logic [2:0]  chip_select_group_n_i,
	input  wire logic        we_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        reset_powerdown_n_i,
	input  wire logic [15:0] busy_cyc_i,
	input  wire logic        fail_i,
	output logic      [15:0] dq_o,
	output logic             status_pin_o
);
	logic        sel;
	logic        wr_q = 1'b0;
	logic        err_q = 1'b0;
	logic [15:0] cnt_q = 16'h0000;
	logic [15:0] float_q = 16'h0000;
	assign sel = chip_select_group_n_i == 3'h0 ||
		(chip_select_group_n_i[2] && chip_select_group_n_i != 3'h7);
	always_ff @(posedge ref_clk_i) begin
		wr_q <= sel && !we_n_i && oe_n_i;
		float_q <= ~float_q;
		if (!reset_powerdown_n_i) begin
			cnt_q <= 16'h0000;
			err_q <= 1'b0;
		end else if (wr_q && !(sel && !we_n_i)) begin
			// Busy length set by the bench, suspend latency included
			cnt_q <= busy_cyc_i;
			err_q <= fail_i;
		end else if (cnt_q != 16'h0000)
			cnt_q <= cnt_q - 16'h0001;
	end
	assign status_pin_o = (reset_powerdown_n_i && cnt_q != 16'h0000) ? 1'b0 : 1'b1;
	// Released bus toggles so a stale value is never mistaken for data
	assign dq_o = (sel && !oe_n_i && reset_powerdown_n_i) ?
		{8'h00, cnt_q == 16'h0000, 1'b0, err_q, err_q, 4'h0} : float_q;
endmodule : afc_flash_model
`default_nettype wire

// ---- tb/async_flash_write_erase_reset_timing_tb_top.sv ----
// Purpose: self-checking bench for the flash write controller
// Assumes: scaled reset, gap and timeout counts
// Notes:   addresses and data of the first six writes drawn from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module async_flash_write_erase_reset_timing_tb_top;
	import afc_pkg::*;
	localparam int RST = 20;
	localparam int GAP = 50;
	logic        ref_clk, rst_n, valid, susp, res, program_enable_supply, frst, fail;
	logic        ready, rv, err, tmo, we_n, oe_n, rpn, sup, dqoe, sts;
	afc_op_e     op;
	afc_to_e     to;
	logic [22:0] addr, ao;
	logic [15:0] wdata, rdata, dqo, dqf, busy;
	logic [2:0]  cs;
	int          seed, fail_count, cmp_count, i;
	afc_ctrl #(.RST_CYC(RST), .GAP_CYC(GAP), .TO_SCALE(100000)) uut (
		.ref_clk_i(ref_clk), .rst_n_i(rst_n), .req_valid_i(valid), .req_op_i(op),
		.req_to_i(to), .req_suspend_i(susp), .req_resume_i(res), .req_program_enable_supply_i(program_enable_supply),
		.req_addr_i(addr), .req_wdata_i(wdata), .flash_reset_i(frst), .req_ready_o(ready),
		.rsp_valid_o(rv), .rsp_rdata_o(rdata), .rsp_error_o(err), .rsp_timeout_o(tmo),
		.chip_select_group_n_o(cs), .we_n_o(we_n), .oe_n_o(oe_n), .reset_powerdown_n_o(rpn),
		.program_enable_supply_o(sup), .addr_o(ao), .dq_o(dqo), .dq_oe_o(dqoe),
		.dq_i(dqoe ? dqo : dqf), .status_pin_i(sts));
	afc_flash_model u_flash (
		.ref_clk_i(ref_clk), .chip_select_group_n_i(cs), .we_n_i(we_n), .oe_n_i(oe_n),
		.reset_powerdown_n_i(rpn), .busy_cyc_i(busy), .fail_i(fail), .dq_o(dqf),
		.status_pin_o(sts));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [31:0] sw(input logic r, input logic f);
		return {24'h0, r, 1'b0, f, f, 4'h0};
	endfunction : sw
	function automatic logic [31:0] exp_to(input int k);
		return (k == AFC_TO_BLOCK || k == AFC_TO_CLR || k == AFC_TO_ERASE) ? 32'h0 : 32'h1;
	endfunction : exp_to
	// Flags are {suspend, resume, supply}
	task automatic req(input afc_op_e o, input afc_to_e t, input logic [2:0] f,
		input logic [22:0] a, input logic [15:0] d);
		int   n;
		logic seen;
		n = 0;
		seen = 1'b0;
		while (ready !== 1'b1 && n < 9000) begin
			@(negedge ref_clk);
			n++;
		end
		{susp, res, program_enable_supply} = f;
		op = o;
		to = t;
		addr = a;
		wdata = d;
		valid = 1'b1;
		@(negedge ref_clk);
		valid = 1'b0;
		while (rv !== 1'b1 && n < 9000) begin
			if (we_n === 1'b0 && !seen) begin
				seen = 1'b1;
				chk(32'(ao), 32'(a));
				chk(32'(dqo), 32'(d));
				chk(32'(dqoe), 32'h1);
			end
			@(negedge ref_clk);
			n++;
		end
		// A request that never completes is a mismatch
		if (n >= 9000) begin
			fail_count++;
			end_sim();
		end
	endtask : req
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		#400000;
		fail_count++;
		end_sim();
	end
	initial begin
		seed = 71;
		{rst_n, valid, susp, res, program_enable_supply, frst, fail} = 7'h00;
		op = AFC_OP_WRITE;
		to = AFC_TO_BUF;
		addr = 23'h000000;
		wdata = 16'h0000;
		busy = 16'h0030;
		repeat (2) @(negedge ref_clk);
		rst_n = 1'b1;
		for (i = 0; i < 6; i++) begin
			busy = 16'h0019 + 16'($unsigned($random(seed)) % 100);
			req(AFC_OP_WRITE, AFC_TO_BUF, 3'h1, 23'($random(seed)), 16'($random(seed)));
			chk(32'(sup), 32'h1);
		end
		// Read straight after a write while the part is still busy
		req(AFC_OP_READ, AFC_TO_BUF, 3'h1, 23'h7FFFFF, 16'h0000);
		chk(32'(rdata), sw(1'b0, 1'b0));
		$display("writes done");
		busy = 16'd150;
		for (i = 0; i < 7; i++) begin
			req(AFC_OP_WRITE, AFC_TO_BUF, 3'h1, 23'h000000, 16'hFFFF);
			req(AFC_OP_WAIT, afc_to_e'(i), 3'h1, 23'h000000, 16'h0000);
			chk(32'(tmo), exp_to(i));
		end
		$display("timeouts done");
		for (i = 1; i >= 0; i--) begin
			fail = i[0];
			req(AFC_OP_WRITE, AFC_TO_BUF, 3'h1, 23'h000040, 16'h1234);
			req(AFC_OP_WAIT, AFC_TO_CLR, 3'h1, 23'h000000, 16'h0000);
			req(AFC_OP_READ, AFC_TO_BUF, 3'h1, 23'h000040, 16'h0000);
			chk(32'(rdata), sw(1'b1, fail));
			repeat (2) @(negedge ref_clk);
			chk(32'(sup), 32'(fail));
		end
		$display("supply done");
		req(AFC_OP_WRITE, AFC_TO_BUF, 3'h2, 23'h000100, 16'h00D0);
		chk(32'(err), 32'h0);
		req(AFC_OP_WRITE, AFC_TO_BUF, 3'h4, 23'h000100, 16'h00B0);
		chk(32'(err), 32'h1);
		repeat (GAP) @(negedge ref_clk);
		req(AFC_OP_WRITE, AFC_TO_BUF, 3'h4, 23'h000100, 16'h00B0);
		chk(32'(err), 32'h0);
		$display("suspend done");
		fail = 1'b1;
		frst = 1'b1;
		@(negedge ref_clk);
		frst = 1'b0;
		repeat (2) @(negedge ref_clk);
		req(AFC_OP_READ, AFC_TO_BUF, 3'h0, 23'h000000, 16'h0000);
		chk(32'(rdata), sw(1'b1, 1'b0));
		req(AFC_OP_WRITE, AFC_TO_BUF, 3'h1, 23'h000010, 16'h5A5A);
		rst_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		rst_n = 1'b1;
		req(AFC_OP_READ, AFC_TO_BUF, 3'h0, 23'h000000, 16'h0000);
		chk(32'(rdata), sw(1'b1, 1'b0));
		$display("resets done");
		end_sim();
	end
endmodule : async_flash_write_erase_reset_timing_tb_top
`default_nettype wire
